// ===== ssec_pkg.sv
`default_nettype none
package ssec_pkg;

    localparam logic [31:0] SSEC_LEAF_BASIC      = 32'h0000_0001;
    localparam logic [31:0] SSEC_LEAF_SAVE       = 32'h0000_000D;
    localparam int          SSEC_LEAF1_SUPPORT_BIT = 26;
    localparam int          SSEC_LEAF1_OS_BIT      = 27;
    localparam int          SSEC_OS_CTRL_BIT       = 18;

    localparam int          SSEC_NUM_COMP        = 10;
    localparam logic [31:0] SSEC_LEGACY_BYTES    = 32'h0000_0240;
    localparam logic [31:0] SSEC_ALIGN_BYTES     = 32'h0000_0040;

    localparam logic [63:0] SSEC_USER_EN_RESET   = 64'h0000_0000_0000_0001;
    localparam logic [63:0] SSEC_SUP_EN_RESET    = 64'h0000_0000_0000_0000;
    localparam logic [63:0] SSEC_USER_RSVD_MASK  = 64'hFFFF_FFFF_FFFF_FD00;

    localparam int          SSEC_FEAT_OPT_SAVE   = 0;
    localparam int          SSEC_FEAT_COMPACT    = 1;
    localparam int          SSEC_FEAT_INIT_READ  = 2;
    localparam int          SSEC_FEAT_PRIV       = 3;

    localparam int          SSEC_BIT_LEGACY      = 0;
    localparam int          SSEC_BIT_SIMD        = 1;
    localparam int          SSEC_BIT_WIDE        = 2;
    localparam int          SSEC_BIT_BND_LO      = 3;
    localparam int          SSEC_BIT_BND_HI      = 4;

    localparam logic [31:0] SSEC_SEL_USER_EN     = 32'h0000_0000;
    localparam logic [31:0] SSEC_SEL_INIT_STATUS = 32'h0000_0001;

    typedef enum logic [3:0] {
        SSEC_OP_ENABLE_READ,
        SSEC_OP_ENABLE_WRITE,
        SSEC_OP_SAVE,
        SSEC_OP_OPT_SAVE,
        SSEC_OP_COMPACT_SAVE,
        SSEC_OP_RESTORE,
        SSEC_OP_COMPACT_RESTORE,
        SSEC_OP_PRIV_SAVE,
        SSEC_OP_PRIV_RESTORE,
        SSEC_OP_SUP_EN_WRITE,
        SSEC_OP_SUP_EN_READ,
        SSEC_OP_WIDE_VECTOR,
        SSEC_OP_BOUNDS,
        SSEC_OP_PACKED_SIMD
    } ssec_op_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] leaf;
        logic [31:0] sub;
    } ssec_query_req_t;

    typedef struct packed {
        logic        done;
        logic [31:0] word_a;
        logic [31:0] word_b;
        logic [31:0] word_c;
        logic [31:0] word_d;
    } ssec_query_rsp_t;

    typedef struct packed {
        logic        valid;
        ssec_op_t    op;
        logic [31:0] sel;
        logic [1:0]  current_privilege_level;
        logic [63:0] data;
    } ssec_insn_req_t;

    typedef struct packed {
        logic        done;
        logic        ud;
        logic        gp;
        logic [63:0] data;
    } ssec_insn_rsp_t;

    typedef struct packed {
        logic            os_en;
        logic [63:0]     user_en;
        logic [63:0]     sup_en;
        ssec_query_rsp_t qrsp;
        ssec_insn_rsp_t  irsp;
        logic            os_done;
    } ssec_state_t;

endpackage
`default_nettype wire

// ===== ssec_ctrl.sv
// Behaviour
// RULE1: leaf1 bit 26 reports support, gates everything but packed simd
// RULE2: os enable settable only when supported
// RULE3: leaf 0DH sub-function from selector word
// RULE4: sub0 user bitmap gates enables; bits 0,1 set
// RULE5: sub0 returns full and enabled save sizes
// RULE6: sub1 bit0 optimized save, else invalid opcode
// RULE7: sub1 bit1 compaction, else compacting save faults
// RULE8: sub1 bit2 reports read selector 1
// RULE9: sub1 bit3 privileged ops; implies bit1; rest zero
// RULE10: sub1 privileged size and supervisor bitmap gating
// RULE11: sub i returns size and user offset
// RULE12: sub i word c flags, word d zero
// RULE13: unsupported component returns all zeros
// RULE14: os enable clear faults all nine instructions
// RULE15: privilege 0 write loads 64 bits, else protection
// RULE16: user enable bit 0 always one
// RULE17: bit 1 resets 0, settable, never gates simd
// RULE18: wide vector needs os enable and bit 2
// RULE19: bit 2 gated by bitmap; 10b faults
// RULE20: bounds needs os enable and bits 11b
// RULE21: bits 4:3 only 00b or 11b
// RULE22: cleared components keep their registers
// RULE23: selector 0 read returns register any privilege
// RULE24: reserved bits zero; setting them faults
`timescale 1ns/1ps
`default_nettype none
module ssec_ctrl
    import ssec_pkg::*;
#(
    parameter logic                              SAVE_SUPPORTED = 1'b1,
    parameter logic [63:0]                       USER_MAP       = 64'h0000_0000_0000_001F,
    parameter logic [63:0]                       SUP_MAP        = 64'h0000_0000_0000_0000,
    parameter logic [3:0]                        SUB1_FEAT      = 4'hF,
    parameter logic [SSEC_NUM_COMP-1:0][31:0]    COMP_SIZE      = '{default: 32'h0000_0040},
    parameter logic [SSEC_NUM_COMP-1:0][31:0]    COMP_OFFSET    = '{default: 32'h0000_0240},
    parameter logic [SSEC_NUM_COMP-1:0]          COMP_ALIGN     = '0
) (
    input  wire logic            clk,
    input  wire logic            rst_b,
    input  wire ssec_query_req_t query_req,
    output var  ssec_query_rsp_t query_rsp,
    input  wire ssec_insn_req_t  insn_req,
    output var  ssec_insn_rsp_t  insn_rsp,
    input  wire logic [63:0]     init_status,
    input  wire logic            os_ctrl_wr,
    input  wire logic [31:0]     os_ctrl_data,
    output logic                 os_ctrl_done,
    output logic                 os_save_enable_bit,
    output logic [63:0]          user_component_enable_reg,
    output logic [63:0]          supervisor_component_enable_reg,
    output logic [63:0]          component_modify_allow
);

    // effective enumeration
    localparam logic [63:0] USER_EFF = USER_MAP | 64'h0000_0000_0000_0003; // RULE4
    localparam logic        PRIV_EFF = SUB1_FEAT[SSEC_FEAT_PRIV] | (|SUP_MAP); // RULE9
    localparam logic [31:0] SUB1_EFF = {28'h000_0000, PRIV_EFF, SUB1_FEAT[SSEC_FEAT_INIT_READ],
                                        SUB1_FEAT[SSEC_FEAT_COMPACT] | PRIV_EFF,
                                        SUB1_FEAT[SSEC_FEAT_OPT_SAVE]}; // RULE9

    ssec_state_t st;
    ssec_state_t next_st;

    // standard layout size of the components in mask
    function automatic logic [31:0] std_size(input logic [63:0] mask);
        logic [31:0] top;
        logic [31:0] end_byte;
        top = SSEC_LEGACY_BYTES;
        for (int i = 2; i < SSEC_NUM_COMP; i++) begin
            end_byte = COMP_OFFSET[i] + COMP_SIZE[i];
            if (mask[i] && end_byte > top) begin
                top = end_byte;
            end
        end
        return top;
    endfunction

    // compacted layout size of the components in mask
    function automatic logic [31:0] compact_size(input logic [63:0] mask);
        logic [31:0] run;
        run = SSEC_LEGACY_BYTES;
        for (int i = 2; i < SSEC_NUM_COMP; i++) begin
            if (mask[i]) begin
                if (COMP_ALIGN[i]) begin
                    run = (run + SSEC_ALIGN_BYTES - 32'h0000_0001) & ~(SSEC_ALIGN_BYTES
                          - 32'h0000_0001);
                end
                run = run + COMP_SIZE[i];
            end
        end
        return run;
    endfunction

    // user enable write check, high when the value must be refused
    function automatic logic user_write_bad(input logic [63:0] v);
        logic bad;
        bad = 1'b0;
        if (!v[SSEC_BIT_LEGACY]) begin
            bad = 1'b1; // RULE16
        end
        if ((v & SSEC_USER_RSVD_MASK) != 64'h0000_0000_0000_0000) begin
            bad = 1'b1; // RULE24
        end
        if ((v & ~USER_EFF) != 64'h0000_0000_0000_0000) begin
            bad = 1'b1; // RULE4
        end
        if (v[SSEC_BIT_WIDE:SSEC_BIT_SIMD] == 2'b10) begin
            bad = 1'b1; // RULE19
        end
        if (v[SSEC_BIT_BND_HI] != v[SSEC_BIT_BND_LO]) begin
            bad = 1'b1; // RULE21
        end
        return bad;
    endfunction

    logic gate_open;
    assign gate_open = SAVE_SUPPORTED & st.os_en;

    always_comb begin
        next_st              = st;
        next_st.qrsp.done    = 1'b0;
        next_st.irsp.done    = 1'b0;
        next_st.irsp.ud      = 1'b0;
        next_st.irsp.gp      = 1'b0;
        next_st.os_done      = 1'b0;
        next_st.user_en[SSEC_BIT_LEGACY] = 1'b1; // RULE16

        // os enable control write
        if (os_ctrl_wr) begin
            next_st.os_done = 1'b1;
            next_st.os_en   = os_ctrl_data[SSEC_OS_CTRL_BIT] & SAVE_SUPPORTED; // RULE2
        end

        // feature queries
        if (query_req.valid) begin
            next_st.qrsp.done   = 1'b1;
            next_st.qrsp.word_a = 32'h0000_0000; // RULE13
            next_st.qrsp.word_b = 32'h0000_0000;
            next_st.qrsp.word_c = 32'h0000_0000;
            next_st.qrsp.word_d = 32'h0000_0000;
            if (query_req.leaf == SSEC_LEAF_BASIC) begin
                next_st.qrsp.word_c[SSEC_LEAF1_SUPPORT_BIT] = SAVE_SUPPORTED; // RULE1
                next_st.qrsp.word_c[SSEC_LEAF1_OS_BIT]      = gate_open;
            end else if (query_req.leaf == SSEC_LEAF_SAVE && SAVE_SUPPORTED) begin // RULE1
                case (query_req.sub) // RULE3
                    32'h0000_0000: begin
                        next_st.qrsp.word_a = USER_EFF[31:0]; // RULE4
                        next_st.qrsp.word_d = USER_EFF[63:32];
                        next_st.qrsp.word_c = std_size(USER_EFF); // RULE5
                        next_st.qrsp.word_b = std_size(st.user_en); // RULE5
                    end
                    32'h0000_0001: begin
                        next_st.qrsp.word_a = SUB1_EFF; // RULE6 RULE7 RULE8 RULE9
                        next_st.qrsp.word_b = compact_size(st.user_en | st.sup_en); // RULE10
                        next_st.qrsp.word_c = SUP_MAP[31:0]; // RULE10
                        next_st.qrsp.word_d = SUP_MAP[63:32];
                    end
                    default: begin
                        if (query_req.sub < SSEC_NUM_COMP) begin
                            if (USER_EFF[query_req.sub[3:0]]) begin
                                next_st.qrsp.word_a = COMP_SIZE[query_req.sub[3:0]]; // RULE11
                                next_st.qrsp.word_b = COMP_OFFSET[query_req.sub[3:0]]; // RULE11
                                next_st.qrsp.word_c = {30'h0000_0000,
                                    COMP_ALIGN[query_req.sub[3:0]], 1'b0}; // RULE12
                            end else if (SUP_MAP[query_req.sub[3:0]]) begin
                                next_st.qrsp.word_a = COMP_SIZE[query_req.sub[3:0]]; // RULE11
                                next_st.qrsp.word_c = {30'h0000_0000,
                                    COMP_ALIGN[query_req.sub[3:0]], 1'b1}; // RULE12
                            end
                        end
                        // unsupported components leave all four words at zero
                    end
                endcase
            end
        end

        // instruction checks
        if (insn_req.valid) begin
            next_st.irsp.done = 1'b1;
            next_st.irsp.data = 64'h0000_0000_0000_0000;
            case (insn_req.op)
                SSEC_OP_ENABLE_READ: begin
                    if (!gate_open) begin
                        next_st.irsp.ud = 1'b1; // RULE14
                    end else if (insn_req.sel == SSEC_SEL_USER_EN) begin
                        next_st.irsp.data = st.user_en; // RULE23
                    end else if (insn_req.sel == SSEC_SEL_INIT_STATUS
                                 && SUB1_EFF[SSEC_FEAT_INIT_READ]) begin
                        next_st.irsp.data = st.user_en & init_status; // RULE8
                    end else begin
                        next_st.irsp.gp = 1'b1;
                    end
                end
                SSEC_OP_ENABLE_WRITE: begin
                    if (!gate_open) begin
                        next_st.irsp.ud = 1'b1; // RULE14
                    end else if (insn_req.current_privilege_level != 2'b00 || insn_req.sel != SSEC_SEL_USER_EN) begin
                        next_st.irsp.gp = 1'b1; // RULE15
                    end else if (user_write_bad(insn_req.data)) begin
                        next_st.irsp.gp = 1'b1; // RULE16 RULE19 RULE21 RULE24
                    end else begin
                        next_st.user_en = insn_req.data; // RULE15 RULE17
                    end
                end
                SSEC_OP_SAVE, SSEC_OP_RESTORE: begin
                    next_st.irsp.ud = !gate_open; // RULE14
                end
                SSEC_OP_OPT_SAVE: begin
                    next_st.irsp.ud = !gate_open || !SUB1_EFF[SSEC_FEAT_OPT_SAVE]; // RULE6
                end
                SSEC_OP_COMPACT_SAVE, SSEC_OP_COMPACT_RESTORE: begin
                    next_st.irsp.ud = !gate_open || !SUB1_EFF[SSEC_FEAT_COMPACT]; // RULE7
                end
                SSEC_OP_PRIV_SAVE, SSEC_OP_PRIV_RESTORE: begin
                    if (!gate_open || !SUB1_EFF[SSEC_FEAT_PRIV]) begin
                        next_st.irsp.ud = 1'b1; // RULE9 RULE14
                    end else if (insn_req.current_privilege_level != 2'b00) begin
                        next_st.irsp.gp = 1'b1;
                    end
                end
                SSEC_OP_SUP_EN_WRITE: begin
                    if (!gate_open || !SUB1_EFF[SSEC_FEAT_PRIV] || insn_req.current_privilege_level != 2'b00) begin
                        next_st.irsp.gp = 1'b1; // RULE9
                    end else if ((insn_req.data & ~SUP_MAP) != 64'h0000_0000_0000_0000) begin
                        next_st.irsp.gp = 1'b1; // RULE10
                    end else begin
                        next_st.sup_en = insn_req.data;
                    end
                end
                SSEC_OP_SUP_EN_READ: begin
                    if (!gate_open || !SUB1_EFF[SSEC_FEAT_PRIV] || insn_req.current_privilege_level != 2'b00) begin
                        next_st.irsp.gp = 1'b1; // RULE9
                    end else begin
                        next_st.irsp.data = st.sup_en;
                    end
                end
                SSEC_OP_WIDE_VECTOR: begin
                    next_st.irsp.ud = !(gate_open && st.user_en[SSEC_BIT_WIDE]); // RULE18
                end
                SSEC_OP_BOUNDS: begin
                    next_st.irsp.ud = !(gate_open && st.user_en[SSEC_BIT_BND_HI]
                                        && st.user_en[SSEC_BIT_BND_LO]); // RULE20
                end
                SSEC_OP_PACKED_SIMD: begin
                    next_st.irsp.ud = 1'b0; // RULE17
                end
                default: begin
                    next_st.irsp.ud = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st.os_en   <= 1'b0;
            st.user_en <= SSEC_USER_EN_RESET; // RULE16 RULE17 RULE19 RULE20 RULE24
            st.sup_en  <= SSEC_SUP_EN_RESET;
            st.qrsp    <= '0;
            st.irsp    <= '0;
            st.os_done <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign query_rsp                        = st.qrsp;
    assign insn_rsp                         = st.irsp;
    assign os_ctrl_done                     = st.os_done;
    assign os_save_enable_bit               = st.os_en;
    assign user_component_enable_reg        = st.user_en;
    assign supervisor_component_enable_reg  = st.sup_en;
    // cleared or gated components are frozen, never zeroed
    assign component_modify_allow = gate_open ? (st.user_en | st.sup_en)
                                              : 64'h0000_0000_0000_0000; // RULE22

endmodule // ssec_ctrl
`default_nettype wire

// ===== ssec_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssec_ctrl_monitor
    import ssec_pkg::*;
#(
    parameter logic SAVE_SUPPORTED = 1'h1
) (
    input wire logic            clk,
    input wire logic            rst_b,
    input wire ssec_query_req_t query_req,
    input wire ssec_query_rsp_t query_rsp,
    input wire ssec_insn_req_t  insn_req,
    input wire ssec_insn_rsp_t  insn_rsp,
    input wire logic [63:0]     init_status,
    input wire logic            os_ctrl_wr,
    input wire logic [31:0]     os_ctrl_data,
    input wire logic            os_ctrl_done,
    input wire logic            os_save_enable_bit,
    input wire logic [63:0]     user_component_enable_reg,
    input wire logic [63:0]     supervisor_component_enable_reg,
    input wire logic [63:0]     component_modify_allow
);
    default clocking mon_clk @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_write_taken;
        insn_req.valid && insn_req.op == SSEC_OP_ENABLE_WRITE && os_save_enable_bit;
    endsequence
    sequence s_fault_seen;
        insn_rsp.done && insn_rsp.gp;
    endsequence
    a_query_answer: assert property (query_req.valid |=> query_rsp.done)
        else $error("query not answered");
    a_os_off_ud: assert property (insn_req.valid && !os_save_enable_bit
        && insn_req.op inside {[SSEC_OP_ENABLE_READ:SSEC_OP_PRIV_RESTORE]} |=> insn_rsp.ud)
        else $error("instruction ran with save disabled");
    a_write_cpl_gp: assert property (s_write_taken ##0 insn_req.current_privilege_level != 2'h0
        |=> insn_rsp.gp && !insn_rsp.ud)
        else $error("privileged write not refused");
    a_write_load: assert property (s_write_taken ##0 insn_req.current_privilege_level == 2'h0
        && insn_req.sel == 32'h0 && insn_req.data == 64'h7 |=> user_component_enable_reg == 64'h7)
        else $error("legal write not loaded");
    a_fault_keeps: assert property (s_fault_seen |-> $stable(user_component_enable_reg))
        else $error("faulting write changed enables");
    a_bit0_set: assert property (user_component_enable_reg[0])
        else $error("enable bit 0 clear");
    a_rsvd_zero: assert property ((user_component_enable_reg & SSEC_USER_RSVD_MASK) == 64'h0)
        else $error("reserved enable bit set");
    a_wide_pair: assert property (user_component_enable_reg[2] |-> user_component_enable_reg[1])
        else $error("wide enabled without simd");
    a_bnd_pair: assert property (user_component_enable_reg[4] == user_component_enable_reg[3])
        else $error("bounds bits split");
    a_os_gate: assert property (os_ctrl_wr |=> os_ctrl_done ##0 (os_save_enable_bit -> SAVE_SUPPORTED))
        else $error("os enable set without support");
    a_modify_gate: assert property (!os_save_enable_bit |-> component_modify_allow == 64'h0)
        else $error("modify allowed with save disabled");
endmodule // ssec_ctrl_monitor
bind ssec_ctrl ssec_ctrl_monitor #(.SAVE_SUPPORTED(SAVE_SUPPORTED)) mon (
    .clk(clk), .rst_b(rst_b), .query_req(query_req), .query_rsp(query_rsp),
    .insn_req(insn_req), .insn_rsp(insn_rsp), .init_status(init_status),
    .os_ctrl_wr(os_ctrl_wr), .os_ctrl_data(os_ctrl_data), .os_ctrl_done(os_ctrl_done),
    .os_save_enable_bit(os_save_enable_bit),
    .user_component_enable_reg(user_component_enable_reg),
    .supervisor_component_enable_reg(supervisor_component_enable_reg),
    .component_modify_allow(component_modify_allow));
`default_nettype wire

// ===== ssec_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ssec_ctrl_tb;
    import ssec_pkg::*;
    localparam logic [63:0] BAD [6] = '{64'h6, 64'h5, 64'h9, 64'h11, 64'h101, 64'h1_0000_0001};
    logic            clk = 1'h0;
    logic            rst_b = 1'h0;
    ssec_query_req_t qreq = '0;
    ssec_query_rsp_t qrsp;
    ssec_insn_req_t  ireq = '0;
    ssec_insn_rsp_t  irsp;
    logic [63:0]     init_st = 64'h3;
    logic            os_wr = 1'h0;
    logic [31:0]     os_data = 32'h0;
    logic            os_done;
    logic            os_en;
    logic [63:0]     user_en;
    logic [63:0]     sup_en;
    logic [63:0]     modify;
    int              n_mismatch = 0;
    int              total_checks = 0;
    always #12.5 clk = ~clk;
    ssec_ctrl dut (
        .clk(clk), .rst_b(rst_b), .query_req(qreq), .query_rsp(qrsp), .insn_req(ireq),
        .insn_rsp(irsp), .init_status(init_st), .os_ctrl_wr(os_wr), .os_ctrl_data(os_data),
        .os_ctrl_done(os_done), .os_save_enable_bit(os_en), .user_component_enable_reg(user_en),
        .supervisor_component_enable_reg(sup_en), .component_modify_allow(modify));
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic q(input logic [31:0] leaf, input logic [31:0] sub);
        @(negedge clk);
        qreq = '{valid: 1'h1, leaf: leaf, sub: sub};
        @(negedge clk);
        qreq.valid = 1'h0;
        chk("query done", 64'h1, {63'h0, qrsp.done});
    endtask
    task automatic ins(input ssec_op_t op, input logic [1:0] current_privilege_level, input logic [63:0] data,
                       input logic [1:0] f, input logic [31:0] sel = 32'h0);
        @(negedge clk);
        ireq = '{valid: 1'h1, op: op, sel: sel, current_privilege_level: current_privilege_level, data: data};
        @(negedge clk);
        ireq.valid = 1'h0;
        chk("insn done ud gp", {61'h0, 1'h1, f}, {61'h0, irsp.done, irsp.ud, irsp.gp});
    endtask
    task automatic os_write(input logic en);
        @(negedge clk);
        os_wr = 1'h1;
        os_data = {13'h0, en, 18'h0};
        @(negedge clk);
        os_wr = 1'h0;
        chk("os done enable", {62'h0, 1'h1, en}, {62'h0, os_done, os_en});
    endtask
    task automatic end_sim();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_b = 1'h1;
        chk("user enable reset", SSEC_USER_EN_RESET, user_en);
        for (int i = 0; i <= 8; i++) begin
            ins(ssec_op_t'(i), 2'h0, 64'h1, 2'h2);
        end
        ins(SSEC_OP_WIDE_VECTOR, 2'h0, 64'h0, 2'h2);
        ins(SSEC_OP_PACKED_SIMD, 2'h3, 64'h0, 2'h0);
        q(SSEC_LEAF_BASIC, 32'h0);
        chk("leaf1 word c", 64'h400_0000, {32'h0, qrsp.word_c & 32'hC00_0000});
        os_write(1'h1);
        q(SSEC_LEAF_BASIC, 32'h0);
        chk("leaf1 os bit", 64'hC00_0000, {32'h0, qrsp.word_c & 32'hC00_0000});
        q(SSEC_LEAF_SAVE, 32'h0);
        chk("sub0 map", 64'h1F, {qrsp.word_d, qrsp.word_a});
        chk("sub0 sizes", {32'h280, 32'h240}, {qrsp.word_c, qrsp.word_b});
        ins(SSEC_OP_ENABLE_WRITE, 2'h1, 64'h7, 2'h1);
        for (int i = 0; i < 6; i++) begin
            ins(SSEC_OP_ENABLE_WRITE, 2'h0, BAD[i], 2'h1);
        end
        chk("user enable kept", SSEC_USER_EN_RESET, user_en);
        ins(SSEC_OP_ENABLE_WRITE, 2'h0, 64'h7, 2'h0);
        ins(SSEC_OP_ENABLE_READ, 2'h3, 64'h0, 2'h0);
        chk("read user enable", 64'h7, irsp.data);
        ins(SSEC_OP_ENABLE_READ, 2'h0, 64'h0, 2'h0, SSEC_SEL_INIT_STATUS);
        chk("read init status", 64'h3, irsp.data);
        q(SSEC_LEAF_SAVE, 32'h0);
        chk("sub0 enabled size", 64'h280, {32'h0, qrsp.word_b});
        ins(SSEC_OP_WIDE_VECTOR, 2'h3, 64'h0, 2'h0);
        ins(SSEC_OP_BOUNDS, 2'h0, 64'h0, 2'h2);
        ins(SSEC_OP_ENABLE_WRITE, 2'h0, 64'h1F, 2'h0);
        ins(SSEC_OP_BOUNDS, 2'h3, 64'h0, 2'h0);
        chk("modify allow", 64'h1F, modify);
        ins(SSEC_OP_ENABLE_WRITE, 2'h0, 64'h3, 2'h0);
        ins(SSEC_OP_WIDE_VECTOR, 2'h0, 64'h0, 2'h2);
        chk("modify allow", 64'h3, modify);
        ins(SSEC_OP_OPT_SAVE, 2'h3, 64'h3, 2'h0);
        ins(SSEC_OP_COMPACT_SAVE, 2'h3, 64'h3, 2'h0);
        ins(SSEC_OP_PRIV_SAVE, 2'h0, 64'h3, 2'h0);
        ins(SSEC_OP_PRIV_RESTORE, 2'h1, 64'h3, 2'h1);
        ins(SSEC_OP_SAVE, 2'h3, 64'h3, 2'h0);
        ins(SSEC_OP_RESTORE, 2'h3, 64'h3, 2'h0);
        ins(SSEC_OP_COMPACT_RESTORE, 2'h3, 64'h3, 2'h0);
        ins(SSEC_OP_SUP_EN_WRITE, 2'h0, 64'h100, 2'h1);
        chk("sup enable kept", SSEC_SUP_EN_RESET, sup_en);
        ins(SSEC_OP_SUP_EN_READ, 2'h3, 64'h0, 2'h1);
        ins(SSEC_OP_SUP_EN_READ, 2'h0, 64'h0, 2'h0);
        chk("read sup enable", SSEC_SUP_EN_RESET, irsp.data);
        q(SSEC_LEAF_SAVE, 32'h1);
        chk("sub1 flags", 64'hF, {32'h0, qrsp.word_a});
        chk("sub1 sup map", 64'h0, {qrsp.word_d, qrsp.word_c});
        q(SSEC_LEAF_SAVE, 32'h2);
        chk("sub2 size offset", {32'h240, 32'h40}, {qrsp.word_b, qrsp.word_a});
        chk("sub2 flags", 64'h0, {qrsp.word_d, qrsp.word_c});
        q(SSEC_LEAF_SAVE, 32'h5);
        chk("sub5 a b", 64'h0, {qrsp.word_b, qrsp.word_a});
        chk("sub5 c d", 64'h0, {qrsp.word_d, qrsp.word_c});
        os_write(1'h0);
        chk("modify allow", 64'h0, modify);
        ins(SSEC_OP_ENABLE_READ, 2'h0, 64'h0, 2'h2);
        end_sim();
    end
endmodule // ssec_ctrl_tb
`default_nettype wire
